// file: src/exception_entry_pkg.sv
package exception_entry_pkg;

   // ------------------------------------------------------------
   // Bus and register map
   // ------------------------------------------------------------
   localparam int         ADDR_W          = 8;
   localparam logic [7:0] OFF_SAVED_RET   = 8'h00;
   localparam logic [7:0] OFF_SAVED_STATE = 8'h04;
   localparam logic [7:0] OFF_MSW         = 8'h08;
   localparam logic [7:0] OFF_FAULT_CAUSE = 8'h0c;
   localparam logic [7:0] OFF_FAULT_ADDR  = 8'h10;
   localparam logic [7:0] OFF_BRK_ADDR    = 8'h14;
   localparam logic [7:0] OFF_LAST_CAUSE  = 8'h18;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;
   localparam logic [31:0] REG_RESET      = 32'h0000_0000;

   // ------------------------------------------------------------
   // Field positions, little-end index (bit n of the word is 31-n)
   // ------------------------------------------------------------
   localparam int MSW_VEC_BASE   = 6;   // vector_base_select
   localparam int MSW_RELOC      = 5;   // instruction_relocation
   localparam int MSW_MCHK_EN    = 12;  // machine_check_enable
   localparam int MSW_ENTRY_BO   = 16;  // entry_byte_order
   localparam int MSW_BO_SWAP    = 0;   // byte_order_swap
   localparam int SAVED_LOW_W    = 16;  // low half copied from state word
   localparam int SAVED_GUARDED  = 28;  // saved-state bit 3
   localparam int SAVED_DENIED   = 27;  // saved-state bit 4
   localparam int CAUSE_DENIED   = 27;  // fault-cause bit 4
   localparam int CAUSE_STORE    = 25;  // fault-cause bit 6

   // ------------------------------------------------------------
   // Vectors
   // ------------------------------------------------------------
   localparam logic [31:0] VEC_BASE_LOW  = 32'h0000_0000;
   localparam logic [31:0] VEC_BASE_HIGH = 32'hfff0_0000;
   localparam logic [31:0] VEC_EMUL      = 32'h0000_1000;
   localparam logic [31:0] VEC_IPROT     = 32'h0000_1300;
   localparam logic [31:0] VEC_DPROT     = 32'h0000_1400;
   localparam logic [31:0] VEC_DBRK      = 32'h0000_1c00;
   localparam logic [31:0] VEC_IBRK      = 32'h0000_1d00;
   localparam logic [31:0] VEC_DP_MASK   = 32'h0000_1e00;
   localparam logic [31:0] VEC_DP_NMASK  = 32'h0000_1f00;

   // ------------------------------------------------------------
   // Entry causes, one-hot
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      CAUSE_NONE  = 7'h00,
      CAUSE_IPROT = 7'h01,
      CAUSE_EMUL  = 7'h02,
      CAUSE_DPROT = 7'h04,
      CAUSE_IBRK  = 7'h08,
      CAUSE_LBRK  = 7'h10,
      CAUSE_NMDBG = 7'h20,
      CAUSE_MDBG  = 7'h40
   } cause_e;

endpackage : exception_entry_pkg

// file: src/exception_entry_state_update.sv
// Summary of operation
// - Entry copies state word bits 16:31 into saved state; bit 30 follows resumable flag.
// - Entry keeps vector base and machine check, copies entry byte order, clears rest.
// - Emulation clears saved-state 10:15 and vectors to 0x01000 off selected base.
// - Fetch protection error on denied fetch or guarded fetch with relocation on.
// - Fetch error sets saved bit 3 guarded, bit 4 denied, clears 1,2,10,11:15.
// - Fetch error saves faulting address and vectors to 0x01300.
// - Data protection error saves instruction address, clears saved-state 1:4 and 10:15.
// - Fault-cause bit 4 denied, bit 6 store; all other fault-cause bits cleared.
// - Data error records access address and vectors to 0x01400.
// - Debug entry on breakpoint match, peripheral request or development port request.
// - Debug return address: faulting, following, or next due instruction per source.
// - Port request held during reset may leave saved registers undefined.
// - Bus breakpoint loads breakpoint address; fault address and cause unchanged.
// - Instruction breakpoints vector 0x01D00, data breakpoints 0x01C00.
// - Maskable port and peripheral requests 0x01E00; non-maskable port 0x01F00.
// - Alignment condition suppresses whole instruction; no data storage vector ever.
// - Partial execution only for multi-access stores.
// - Later-access store protection error may partially complete; base not updated.
// - Unimplemented optional facilities take the emulation entry.
// - Illegal, unimplemented optional and floating-point instructions take emulation entry.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module exception_entry_state_update
   import exception_entry_pkg::*;
#(
   parameter logic [31:0] HIGH_BASE = VEC_BASE_HIGH
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Pipeline and checkers
   input  wire logic              fetch_check,
   input  wire logic              fetch_denied,
   input  wire logic              fetch_guarded,
   input  wire logic [31:0]       fetch_pc,
   input  wire logic              illegal_insn,
   input  wire logic              unimpl_optional,
   input  wire logic              float_insn,
   input  wire logic [31:0]       fault_pc,
   input  wire logic [31:0]       next_pc,
   input  wire logic              data_check,
   input  wire logic              data_denied,
   input  wire logic              data_is_store,
   input  wire logic              data_multi_access,
   input  wire logic              data_first_access,
   input  wire logic [31:0]       data_ea,
   input  wire logic              align_detect,
   input  wire logic              ibrk_match,
   input  wire logic              lbrk_match,
   input  wire logic [31:0]       lbrk_ea,
   input  wire logic              periph_brk_req,
   input  wire logic              devport_req,
   input  wire logic              devport_nonmask,
   // Entry results
   output logic                   redirect_valid,
   output logic [31:0]            redirect_pc,
   output logic [6:0]             entry_cause,
   output logic                   keep_partial,
   output logic                   base_update_inhibit,
   output logic                   suppress_insn,
   output logic [31:0]            machine_state_word
);

   if (HIGH_BASE[15:0] != 16'h0000) begin : g_bad_base
      $error("HIGH_BASE must clear its low 16 bits");
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [31:0] saved_return_address_reg;
   logic [31:0] saved_machine_state_reg;
   logic [31:0] msw_reg;
   logic [31:0] data_fault_cause_reg;
   logic [31:0] data_fault_address_reg;
   logic [31:0] breakpoint_address_reg;
   cause_e      last_cause_reg;
   logic [2:1]  dp_sync1_reg, dp_sync2_reg, dp_sync3_reg;
   logic        dp_req_reg, dp_nm_reg;
   logic        in_reset_reg, dp_at_reset_reg;
   logic        aw_full_reg, w_full_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;

   cause_e      cause_next;
   logic [31:0] saved_return_address_next, saved_machine_state_next, msw_next, vec_next;
   logic        take, wr_fire, dbg_entry, skip_saved;
   logic [31:0] rd_data;
   logic        rd_hit, wr_hit;

   // Merge write data under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) res[i*8 +: 8] = data[i*8 +: 8];
      end
      return res;
   endfunction : merge

   function automatic logic wr_at(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      return a[ADDR_W-1:2] == off[7:2];
   endfunction : wr_at

   // ------------------------------------------------------------
   // Development port request synchroniser
   // ------------------------------------------------------------
   // Chain has no reset so a request held during reset is still seen
   always_ff @(posedge aclk) begin
      dp_sync1_reg <= {devport_nonmask, devport_req};
      dp_sync2_reg <= dp_sync1_reg;
      dp_sync3_reg <= dp_sync2_reg;
   end

   // Accept a level once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dp_req_reg <= 1'b0;
         dp_nm_reg  <= 1'b0;
      end else begin
         if (dp_sync2_reg[1] == dp_sync3_reg[1]) dp_req_reg <= dp_sync3_reg[1];
         if (dp_sync2_reg[2] == dp_sync3_reg[2]) dp_nm_reg  <= dp_sync3_reg[2];
      end
   end

   // Flag a port request present right at reset release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_reset_reg    <= 1'b1;
         dp_at_reset_reg <= 1'b0;
      end else begin
         in_reset_reg <= 1'b0;
         if (in_reset_reg) begin
            dp_at_reset_reg <= dp_sync3_reg[1];
         end else if (dbg_entry) begin
            dp_at_reset_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Cause selection, fixed priority, one entry per boundary
   // ------------------------------------------------------------
   always_comb begin
      cause_next = CAUSE_NONE;
      if (redirect_valid) begin
         cause_next = CAUSE_NONE;
      end else if (fetch_check && (fetch_denied || (fetch_guarded && msw_reg[MSW_RELOC]))) begin
         cause_next = CAUSE_IPROT;
      end else if (illegal_insn || unimpl_optional || float_insn) begin
         cause_next = CAUSE_EMUL;
      end else if (data_check && data_denied && !align_detect) begin
         cause_next = CAUSE_DPROT;
      end else if (ibrk_match) begin
         cause_next = CAUSE_IBRK;
      end else if (lbrk_match) begin
         cause_next = CAUSE_LBRK;
      end else if (dp_req_reg && dp_nm_reg) begin
         cause_next = CAUSE_NMDBG;
      end else if (dp_req_reg || periph_brk_req) begin
         cause_next = CAUSE_MDBG;
      end
   end

   assign take       = cause_next != CAUSE_NONE;
   assign dbg_entry  = cause_next inside {CAUSE_NMDBG, CAUSE_MDBG};
   assign skip_saved = dbg_entry && dp_req_reg && dp_at_reset_reg;

   // ------------------------------------------------------------
   // Entry values
   // ------------------------------------------------------------
   always_comb begin
      // Low half from state word, bits 1:4 and 10:15 and the rest zero
      saved_machine_state_next = REG_RESET;
      saved_machine_state_next[SAVED_LOW_W-1:0] = msw_reg[SAVED_LOW_W-1:0];
      if (cause_next == CAUSE_IPROT) begin
         saved_machine_state_next[SAVED_GUARDED] = fetch_guarded && msw_reg[MSW_RELOC];
         saved_machine_state_next[SAVED_DENIED]  = fetch_denied;
      end
      // New state word keeps base select and machine check, takes byte order swap from entry byte order
      msw_next = REG_RESET;
      msw_next[MSW_VEC_BASE] = msw_reg[MSW_VEC_BASE];
      msw_next[MSW_MCHK_EN]  = msw_reg[MSW_MCHK_EN];
      msw_next[MSW_BO_SWAP]  = msw_reg[MSW_ENTRY_BO];
      // Return address and vector offset per cause
      saved_return_address_next = fault_pc;
      vec_next  = VEC_EMUL;
      case (cause_next)
         CAUSE_IPROT: begin
            saved_return_address_next = fetch_pc;
            vec_next  = VEC_IPROT;
         end
         CAUSE_EMUL: begin
            saved_return_address_next = fault_pc;
            vec_next  = VEC_EMUL;
         end
         CAUSE_DPROT: begin
            saved_return_address_next = fault_pc;
            vec_next  = VEC_DPROT;
         end
         CAUSE_IBRK: begin
            saved_return_address_next = fault_pc;
            vec_next  = VEC_IBRK;
         end
         CAUSE_LBRK: begin
            saved_return_address_next = next_pc;
            vec_next  = VEC_DBRK;
         end
         CAUSE_NMDBG: begin
            saved_return_address_next = next_pc;
            vec_next  = VEC_DP_NMASK;
         end
         CAUSE_MDBG: begin
            saved_return_address_next = next_pc;
            vec_next  = VEC_DP_MASK;
         end
         default: begin
            saved_return_address_next = fault_pc;
            vec_next  = VEC_EMUL;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Redirect and side outputs, registered every cycle; redirect_pc only on an entry
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         redirect_valid      <= 1'b0;
         redirect_pc         <= REG_RESET;
         entry_cause         <= CAUSE_NONE;
         keep_partial        <= 1'b0;
         base_update_inhibit <= 1'b0;
         suppress_insn       <= 1'b0;
      end else begin
         redirect_valid <= take;
         entry_cause    <= cause_next;
         if (take) begin
            redirect_pc <= (msw_reg[MSW_VEC_BASE] ? HIGH_BASE : VEC_BASE_LOW) | vec_next;
         end
         keep_partial <= (cause_next == CAUSE_DPROT) && data_multi_access
                         && data_is_store && !data_first_access;
         base_update_inhibit <= cause_next == CAUSE_DPROT;
         suppress_insn <= align_detect;
      end
   end

   // ------------------------------------------------------------
   // Saved and state registers; hardware entry wins over software
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         saved_return_address_reg <= REG_RESET;
         saved_machine_state_reg  <= REG_RESET;
      end else if (take && !skip_saved) begin
         saved_return_address_reg <= saved_return_address_next;
         saved_machine_state_reg  <= saved_machine_state_next;
      end else if (take) begin
         saved_return_address_reg <= saved_return_address_reg;
      end else if (wr_fire && wr_at(aw_addr_reg, OFF_SAVED_RET)) begin
         saved_return_address_reg <= merge(saved_return_address_reg, w_data_reg, w_strb_reg);
      end else if (wr_fire && wr_at(aw_addr_reg, OFF_SAVED_STATE)) begin
         saved_machine_state_reg <= merge(saved_machine_state_reg, w_data_reg, w_strb_reg);
      end
   end

   // State word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         msw_reg <= REG_RESET;
      end else if (take) begin
         msw_reg <= msw_next;
      end else if (wr_fire && wr_at(aw_addr_reg, OFF_MSW)) begin
         msw_reg <= merge(msw_reg, w_data_reg, w_strb_reg);
      end
   end

   // Fault cause and fault address, loaded only on data protection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_fault_cause_reg   <= REG_RESET;
         data_fault_address_reg <= REG_RESET;
      end else if (cause_next == CAUSE_DPROT) begin
         data_fault_cause_reg <= REG_RESET;
         data_fault_cause_reg[CAUSE_DENIED] <= data_denied;
         data_fault_cause_reg[CAUSE_STORE]  <= data_is_store;
         data_fault_address_reg <= data_ea;
      end else if (wr_fire && wr_at(aw_addr_reg, OFF_FAULT_CAUSE)) begin
         data_fault_cause_reg <= merge(data_fault_cause_reg, w_data_reg, w_strb_reg);
      end else if (wr_fire && wr_at(aw_addr_reg, OFF_FAULT_ADDR)) begin
         data_fault_address_reg <= merge(data_fault_address_reg, w_data_reg, w_strb_reg);
      end
   end

   // Breakpoint address, fault registers left alone on bus breakpoint
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         breakpoint_address_reg <= REG_RESET;
      end else if (cause_next == CAUSE_LBRK) begin
         breakpoint_address_reg <= lbrk_ea;
      end else if (wr_fire && wr_at(aw_addr_reg, OFF_BRK_ADDR)) begin
         breakpoint_address_reg <= merge(breakpoint_address_reg, w_data_reg, w_strb_reg);
      end
   end

   // Last entry cause, read-only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_cause_reg <= CAUSE_NONE;
      end else if (take) begin
         last_cause_reg <= cause_next;
      end
   end

   assign machine_state_word = msw_reg;

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;

   always_comb begin
      wr_hit = 1'b0;
      for (int i = 0; i < 6; i++) begin
         if (wr_at(aw_addr_reg, 8'(i * 4))) wr_hit = 1'b1;
      end
   end

   // Address and data taken in either order, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg   <= 1'b0;
         w_full_reg    <= 1'b0;
         aw_addr_reg   <= '0;
         w_data_reg    <= REG_RESET;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg   <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   always_comb begin
      rd_hit  = 1'b1;
      rd_data = REG_RESET;
      case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
         OFF_SAVED_RET:   rd_data = saved_return_address_reg;
         OFF_SAVED_STATE: rd_data = saved_machine_state_reg;
         OFF_MSW:         rd_data = msw_reg;
         OFF_FAULT_CAUSE: rd_data = data_fault_cause_reg;
         OFF_FAULT_ADDR:  rd_data = data_fault_address_reg;
         OFF_BRK_ADDR:    rd_data = breakpoint_address_reg;
         OFF_LAST_CAUSE:  rd_data = {25'h0, last_cause_reg};
         default:         rd_hit  = 1'b0;
      endcase
   end

   // One read at a time, data sampled at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= REG_RESET;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : exception_entry_state_update

`default_nettype wire

// file: sim/exception_entry_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module exception_entry_monitor
   import exception_entry_pkg::*;
#(
   parameter logic [31:0] HIGH_BASE = VEC_BASE_HIGH
) (
   input wire logic        aclk, aresetn, fetch_check, fetch_denied, illegal_insn,
   input wire logic        periph_brk_req, align_detect, redirect_valid, keep_partial,
   input wire logic        base_update_inhibit, suppress_insn,
   input wire logic [6:0]  entry_cause,
   input wire logic [31:0] redirect_pc, machine_state_word
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Vector offset for each entry cause
   function automatic logic [31:0] vec_of(input logic [6:0] c);
      case (c)
         CAUSE_IPROT: return VEC_IPROT;
         CAUSE_EMUL:  return VEC_EMUL;
         CAUSE_DPROT: return VEC_DPROT;
         CAUSE_IBRK:  return VEC_IBRK;
         CAUSE_LBRK:  return VEC_DBRK;
         CAUSE_NMDBG: return VEC_DP_NMASK;
         default:     return VEC_DP_MASK;
      endcase
   endfunction : vec_of
   a_vector_pick: assert property (redirect_valid |-> redirect_pc ==
      (vec_of(entry_cause) | (machine_state_word[MSW_VEC_BASE] ? HIGH_BASE : VEC_BASE_LOW)))
      else $error("entry vector wrong");
   a_fetch_entry: assert property (!redirect_valid && fetch_check && fetch_denied
      |=> redirect_valid && entry_cause == CAUSE_IPROT) else $error("fetch error not taken");
   a_emul_entry: assert property (!redirect_valid && illegal_insn && !fetch_check
      |=> entry_cause == CAUSE_EMUL) else $error("emulation not taken");
   a_state_clear: assert property (redirect_valid |-> machine_state_word ==
      ($past(machine_state_word) & 32'h0000_1040 | {31'h0, $past(machine_state_word[16])}))
      else $error("state word not rewritten");
   a_pulse_one: assert property (redirect_valid |=> !redirect_valid && entry_cause == 7'h00)
      else $error("redirect longer than one cycle");
   a_align_block: assert property (align_detect |=> suppress_insn && entry_cause != CAUSE_DPROT)
      else $error("alignment not suppressed");
   a_partial_dprot: assert property (keep_partial |-> redirect_valid && base_update_inhibit
      && entry_cause == CAUSE_DPROT) else $error("partial store outside data error");
   a_debug_take: assert property (!redirect_valid && periph_brk_req |=> redirect_valid)
      else $error("peripheral request not taken");
endmodule : exception_entry_monitor
bind exception_entry_state_update exception_entry_monitor #(.HIGH_BASE(HIGH_BASE))
   exception_entry_monitor_inst (.aclk,
   .aresetn, .fetch_check, .fetch_denied, .illegal_insn, .periph_brk_req, .align_detect,
   .redirect_valid, .keep_partial, .base_update_inhibit, .suppress_insn, .entry_cause,
   .redirect_pc, .machine_state_word);
`default_nettype wire

// file: sim/core_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
   input  wire logic        aclk, aresetn, redirect_valid,
   input  wire logic [6:0]  req,
   output logic [6:0]       ev,
   output logic [31:0]      pc
);
   // Each request is held until the entry is seen
   always_ff @(posedge aclk) begin
      if (!aresetn) ev <= 7'h00;
      else if (redirect_valid) ev <= 7'h00;
      else ev <= ev | req;
   end
   // Program counter stalls while an event is pending
   always_ff @(posedge aclk) begin
      if (!aresetn) pc <= 32'h0000_0100;
      else if (ev == 7'h00) pc <= pc + 32'h4;
   end
endmodule : core_side_model
`default_nettype wire

// file: sim/exception_entry_state_update_test.sv
`timescale 1ns/1ps
`default_nettype none
module exception_entry_state_update_test;
   import exception_entry_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, align_detect = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, redirect_valid, keep_partial;
   logic base_update_inhibit, suppress_insn;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [6:0]  req = 7'h00, ev, entry_cause;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, redirect_pc, machine_state_word, pc, seen;
   logic [31:0] exp_r [6];
   logic [31:0] vecs [7] = '{VEC_IPROT, VEC_EMUL, VEC_DPROT, VEC_IBRK, VEC_DBRK, VEC_DP_NMASK,
                             VEC_DP_MASK};
   int order [7] = '{0, 1, 2, 3, 4, 6, 5};
   int err_total = 0, comparisons = 0, n, k;
   wire logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   wire logic [3:0] s_axi_wstrb = 4'hf;
   wire logic fetch_check = ev[0], fetch_denied = ev[0], fetch_guarded = ev[0];
   wire logic illegal_insn = ev[1], unimpl_optional = ev[1], float_insn = ev[1];
   wire logic data_check = ev[2], data_denied = ev[2], data_is_store = ev[2];
   wire logic data_multi_access = ev[2], data_first_access = 1'b0, ibrk_match = ev[3];
   wire logic lbrk_match = ev[4], devport_req = ev[5], devport_nonmask = ev[5];
   wire logic periph_brk_req = ev[6];
   wire logic [31:0] fetch_pc = pc, fault_pc = pc, next_pc = pc + 32'h4;
   wire logic [31:0] data_ea = pc ^ 32'h0055_0000, lbrk_ea = pc ^ 32'h00aa_0000;
   exception_entry_state_update exception_entry_state_update_inst (.*);
   core_side_model core_side_model_inst (.aclk, .aresetn, .redirect_valid, .req, .ev, .pc);
   initial forever #12.5 aclk = ~aclk;
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wrap_up;
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   // Register bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, v;
      @(posedge aclk);
      {aw, w} = 2'b11;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(negedge aclk);
         aw = aw && !s_axi_awready;
         w = w && !s_axi_wready;
         v = s_axi_bvalid;
         @(posedge aclk);
         {s_axi_awvalid, s_axi_wvalid} <= {aw, w};
      end while (!v);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, v;
      @(posedge aclk);
      ar = 1'b1;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(negedge aclk);
         ar = ar && !s_axi_arready;
         {v, d, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
         @(posedge aclk);
         s_axi_arvalid <= ar;
      end while (!v);
      s_axi_rready <= 1'b0;
   endtask : rd
   initial begin
      #200000 err_total++;
      wrap_up();
   end
   // One entry per cause, each but the non-maskable port entry followed by a read-back of registers 0x00 to 0x14
   initial begin
      exp_r = '{default: 32'h0};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int j = 0; j < 7; j++) begin
         k = order[j];
         wr(OFF_MSW, 32'h0001_5a63);
         @(posedge aclk) req <= 7'h01 << k;
         @(posedge aclk) req <= 7'h00;
         n = 0;
         do begin
            @(negedge aclk);
            n++;
         end while (!redirect_valid && n < 40);
         check("entry", {24'h0, redirect_valid, entry_cause}, {25'h1, 7'h01 << k});
         check("vector", redirect_pc, VEC_BASE_HIGH | vecs[k]);
         check("partial", {31'h0, keep_partial}, {31'h0, k == 2});
         check("inhibit", {31'h0, base_update_inhibit}, {31'h0, k == 2});
         check("state", machine_state_word, 32'h0000_1041);
         exp_r[0] = (k < 4) ? pc : pc + 32'h4;
         exp_r[1] = (k == 0) ? 32'h1800_5a63 : 32'h0000_5a63;
         exp_r[2] = 32'h0000_1041;
         exp_r[3] = (k == 2) ? 32'h0a00_0000 : exp_r[3];
         exp_r[4] = (k == 2) ? data_ea : exp_r[4];
         exp_r[5] = (k == 4) ? lbrk_ea : exp_r[5];
         for (int i = 0; i < 6 && k != 5; i++) begin
            rd(8'(4 * i), seen, resp);
            check("register", seen, exp_r[i]);
         end
      end
      @(posedge aclk) align_detect <= 1'b1;
      @(posedge aclk) align_detect <= 1'b0;
      @(negedge aclk) check("suppress", {31'h0, suppress_insn}, 32'h1);
      rd(8'h1c, seen, resp);
      check("unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
      wrap_up();
   end
endmodule : exception_entry_state_update_test
`default_nettype wire
